/* File: pkg/pd_bmc_cfg.svh */
// Timing and reset constants of the biphase-mark line coder
`ifndef PD_BMC_CFG_SVH
`define PD_BMC_CFG_SVH

// =============================================================
// Clock
`define PD_CLK_MHZ          40

// =============================================================
// Bit timing in ns
`define PD_UI_NS            3333
`define PD_RX_SHORT_NS      757
`define PD_RX_HALF_MAX_NS   2500
`define PD_RX_FULL_MAX_NS   4630

// =============================================================
// Derived cycle counts; least times round up, longest round down
`define PD_UI_CYC           ((`PD_UI_NS * `PD_CLK_MHZ) / 1000)
`define PD_RX_SHORT_CYC     ((`PD_RX_SHORT_NS * `PD_CLK_MHZ + 999) / 1000)
`define PD_RX_HALF_MAX_CYC  ((`PD_RX_HALF_MAX_NS * `PD_CLK_MHZ) / 1000)
`define PD_RX_FULL_MAX_CYC  ((`PD_RX_FULL_MAX_NS * `PD_CLK_MHZ) / 1000)

// =============================================================
// Preamble length and reset values
`define PD_PREAMBLE_BITS    64
`define PD_LEVEL_RST        4'h0

`endif

/* File: pkg/pd_bmc_pkg.sv */
// Types shared by the biphase-mark line coder
package pd_bmc_pkg;

    // =========================================================
    // Transmit sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_ENABLE = 2'b01,
        ST_CELL   = 2'b10,
        ST_CLOSE  = 2'b11
    } tx_state_t;

endpackage

/* File: pkg/rx_link_if.sv */
// Link between the line coder and its receive decoder
`timescale 1ns/100ps

interface rx_link_if;
    logic line_in;
    logic enable;
    logic bit_valid;
    logic bit_value;
    logic bit_error;

    modport phy
    (
        output line_in,
        output enable,
        input  bit_valid,
        input  bit_value,
        input  bit_error
    );

    modport decoder
    (
        input  line_in,
        input  enable,
        output bit_valid,
        output bit_value,
        output bit_error
    );
endinterface

/* File: logic/bmc_rx_decoder.sv */
// Receive decoder: edge interval measurement and bit recovery
`timescale 1ns/100ps
`include "pd_bmc_cfg.svh"

module bmc_rx_decoder
    import pd_bmc_pkg::*;
#(
    parameter int SHORT_CYC    = `PD_RX_SHORT_CYC,
    parameter int HALF_MAX_CYC = `PD_RX_HALF_MAX_CYC,
    parameter int FULL_MAX_CYC = `PD_RX_FULL_MAX_CYC
)
(
    input wire logic   clk_sys,
    input wire logic   nrst,
    rx_link_if.decoder link
);

    logic [7:0] gap;
    logic       prev;
    logic       half_seen;
    logic       edge_seen;
    logic       short_gap;
    logic       half_gap;
    logic       full_gap;

    assign edge_seen = link.enable && (link.line_in != prev);
    assign short_gap = gap < 8'(SHORT_CYC);
    assign half_gap  = !short_gap && (gap <= 8'(HALF_MAX_CYC));
    assign full_gap  = !short_gap && !half_gap
                       && (gap <= 8'(FULL_MAX_CYC));

    // =========================================================
    // Interval counter; saturation marks an idle line
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            // Start saturated so the first edge after reset only times
            gap  <= 8'hff;
            prev <= 1'b0;
        end
        else
        begin
            prev <= link.line_in;
            // Own transmission counts as idle; the release edge is no bit
            if (!link.enable)
                gap <= 8'hff;
            else if (edge_seen)
                gap <= 8'h01;
            else if (gap != 8'hff)
                gap <= gap + 8'h01;
        end
    end

    // =========================================================
    // Bit recovery; an edge after a long gap only starts timing,
    // so a lost first preamble edge costs nothing
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            half_seen      <= 1'b0;
            link.bit_valid <= 1'b0;
            link.bit_value <= 1'b0;
            link.bit_error <= 1'b0;
        end
        else
        begin
            link.bit_valid <= 1'b0;
            link.bit_error <= 1'b0;
            if (!link.enable)
                half_seen <= 1'b0;
            else if (edge_seen)
            begin
                if (short_gap)
                begin
                    link.bit_error <= 1'b1;
                    half_seen      <= 1'b0;
                end
                else if (half_gap)
                begin
                    half_seen <= !half_seen;
                    if (half_seen)
                    begin
                        link.bit_valid <= 1'b1;
                        link.bit_value <= 1'b1;
                    end
                end
                else if (full_gap)
                begin
                    half_seen <= 1'b0;
                    if (half_seen)
                        link.bit_error <= 1'b1;
                    else
                    begin
                        link.bit_valid <= 1'b1;
                        link.bit_value <= 1'b0;
                    end
                end
                else
                    half_seen <= 1'b0;
            end
        end
    end

    a_rx_short_error:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_seen && short_gap) |=> link.bit_error && !link.bit_valid)
    else $error("short interval not flagged");

    a_rx_two_halves:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        (edge_seen && half_gap && half_seen)
        |=> link.bit_valid && link.bit_value)
    else $error("two half intervals did not give a one");

endmodule

/* File: logic/pd_bmc_line_phy.sv */
// Biphase-mark line coder for the configuration channel wire
//
// How it works
// - Every bit cell starts with a transition
// - One bits add a mid-cell transition
// - Disparity bounded: no level held longer than one bit
// - Preamble starts by driving the line low
// - One closing edge follows the last bit
// - Only the orientation-selected pin carries traffic
// - Driver overrides pin bias while sending
// - Driver released to high impedance when idle
// - Firmware-set peak level selects drive levels
`timescale 1ns/100ps
`include "pd_bmc_cfg.svh"

module pd_bmc_line_phy
    import pd_bmc_pkg::*;
#(
    parameter int BIT_CYCLES    = `PD_UI_CYC,
    parameter int PREAMBLE_BITS = `PD_PREAMBLE_BITS,
    parameter int LEVEL_W       = 4
)
(
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    input  wire logic               orientation,
    input  wire logic [LEVEL_W-1:0] tx_peak_level,
    input  wire logic               tx_start,
    input  wire logic               tx_valid,
    input  wire logic               tx_bit,
    input  wire logic               tx_last,
    output      logic               tx_ready,
    output      logic               tx_busy,
    output      logic               tx_underrun,
    output      logic [LEVEL_W-1:0] tx_level,
    input  wire logic               config_channel_pin_a_in,
    output      logic               config_channel_pin_a_out,
    output      logic               config_channel_pin_a_oe,
    input  wire logic               config_channel_pin_b_in,
    output      logic               config_channel_pin_b_out,
    output      logic               config_channel_pin_b_oe,
    output      logic               rx_bit_valid,
    output      logic               rx_bit_value,
    output      logic               rx_bit_error
);

    localparam int HALF_CYCLES = BIT_CYCLES / 2;

    tx_state_t  state;
    logic [7:0] cnt;
    logic [7:0] pre_idx;
    logic       line;
    logic       cur_bit;
    logic       last_flag;
    logic       drive;
    logic       orient_q;
    logic       cell_end;
    logic       in_preamble;
    logic       selected_config_channel_pin;
    logic [7:0] run;
    logic       line_q;

    rx_link_if link ();

    assign cell_end    = (state == ST_CELL) && (cnt == 8'(BIT_CYCLES - 1));
    assign in_preamble = pre_idx != 8'(PREAMBLE_BITS);
    assign tx_ready    = cell_end && !last_flag && !in_preamble;
    assign tx_busy     = drive;

    // =========================================================
    // Transmit sequencer; underrun ends the frame like a last bit
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state       <= ST_IDLE;
            cnt         <= 8'h00;
            pre_idx     <= 8'h00;
            line        <= 1'b0;
            cur_bit     <= 1'b0;
            last_flag   <= 1'b0;
            tx_underrun <= 1'b0;
        end
        else
        begin
            tx_underrun <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    line      <= 1'b0;
                    cnt       <= 8'h00;
                    pre_idx   <= 8'h00;
                    last_flag <= 1'b0;
                    if (tx_start)
                        state <= ST_ENABLE;
                end
                ST_ENABLE:
                begin
                    state   <= ST_CELL;
                    line    <= !line;
                    cur_bit <= 1'b0;
                    pre_idx <= 8'h01;
                end
                ST_CELL:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(HALF_CYCLES - 1) && cur_bit)
                        line <= !line;
                    if (cell_end)
                    begin
                        cnt  <= 8'h00;
                        line <= !line;
                        if (last_flag)
                            state <= ST_CLOSE;
                        else if (in_preamble)
                        begin
                            cur_bit <= pre_idx[0];
                            pre_idx <= pre_idx + 8'h01;
                        end
                        else if (tx_valid)
                        begin
                            cur_bit   <= tx_bit;
                            last_flag <= tx_last;
                        end
                        else
                        begin
                            state       <= ST_CLOSE;
                            tx_underrun <= 1'b1;
                        end
                    end
                end
                ST_CLOSE:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt == 8'(HALF_CYCLES - 1))
                    begin
                        state <= ST_IDLE;
                        line  <= 1'b0;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // Driver enable, orientation and peak level are frozen per frame
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            drive    <= 1'b0;
            orient_q <= 1'b0;
            tx_level <= LEVEL_W'(`PD_LEVEL_RST);
        end
        else
        begin
            if (state == ST_IDLE && tx_start)
            begin
                drive    <= 1'b1;
                orient_q <= orientation;
                tx_level <= tx_peak_level;
            end
            else if (state == ST_CLOSE && cnt == 8'(HALF_CYCLES - 1))
                drive <= 1'b0;
        end
    end

    // =========================================================
    // Pin steering; the unselected pin is never driven
    assign config_channel_pin_a_oe  = drive && !orient_q;
    assign config_channel_pin_b_oe  = drive && orient_q;
    assign config_channel_pin_a_out = line && !orient_q;
    assign config_channel_pin_b_out = line && orient_q;

    // =========================================================
    // Receive path listens only to the selected pin, and not to
    // our own transmission
    assign selected_config_channel_pin = orientation ?
        config_channel_pin_b_in : config_channel_pin_a_in;
    assign link.line_in = selected_config_channel_pin;
    assign link.enable  = !drive;
    assign rx_bit_valid = link.bit_valid;
    assign rx_bit_value = link.bit_value;
    assign rx_bit_error = link.bit_error;

    // A lost first edge just lands in the idle-gap branch
    bmc_rx_decoder u_rx
    (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .link    (link)
    );

    // =========================================================
    // Run length helper for the disparity check
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            run    <= 8'h00;
            line_q <= 1'b0;
        end
        else
        begin
            line_q <= line;
            if (state != ST_CELL || line != line_q)
                run <= 8'h00;
            else if (run != 8'hff)
                run <= run + 8'h01;
        end
    end

    a_run_bounded:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        run <= 8'(BIT_CYCLES))
    else $error("line held longer than one bit");

    a_cell_edge:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        cell_end |=> line != $past(line))
    else $error("bit cell did not start with an edge");

    a_mid_edge:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_CELL && cnt == 8'(HALF_CYCLES - 1))
        |=> ((line != $past(line)) == $past(cur_bit)))
    else $error("mid-cell edge does not match bit value");

    a_start_low:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_ENABLE) |-> drive && !line ##1 line)
    else $error("preamble did not start low");

    a_close_edge:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(state == ST_CLOSE) |-> line != $past(line) && drive)
    else $error("missing closing edge");

    a_pin_select:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        !(config_channel_pin_a_oe && config_channel_pin_b_oe)
        && !(config_channel_pin_a_oe && orient_q))
    else $error("unselected pin driven");

    a_drive_override:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_CELL || state == ST_CLOSE)
        |-> config_channel_pin_a_oe || config_channel_pin_b_oe)
    else $error("driver not enabled while sending");

    a_idle_release:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        (state == ST_IDLE)
        |-> !config_channel_pin_a_oe && !config_channel_pin_b_oe)
    else $error("pin driven while idle");

    a_peak_level:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(drive) |-> tx_level == $past(tx_peak_level))
    else $error("peak level not taken at frame start");

    a_enable_trail:
    assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(drive) |-> $past(state) == ST_CLOSE
        && $past(cnt) == 8'(HALF_CYCLES - 1))
    else $error("driver released before half bit after close");

endmodule

/* File: test/pd_remote_port.sv */
// Remote port model sharing the configuration channel wire
`timescale 1ns/100ps

module pd_remote_port
(
    input  wire logic clk_sys,
    input  wire logic line,
    input  wire logic listen,
    output      logic drv_oe,
    output      logic drv_val,
    output      logic got,
    output      logic got_bit
);
    logic prev;
    logic half;
    int   cnt;

    initial
    begin
        drv_oe  = 1'b0;
        drv_val = 1'b1;
        got     = 1'b0;
        got_bit = 1'b0;
        half    = 1'b0;
        cnt     = 0;
    end

    // ==========================================================
    // Encoder towards the block
    task automatic flip(input int n);
        repeat (n) @(posedge clk_sys);
        drv_val <= ~drv_val;
    endtask

    // Only sends a bad interval when the bench passes glitch
    task automatic send(input logic [31:0] bits, input int n,
                        input int glitch);
        int i;
        @(posedge clk_sys);
        // Start at the bias level so enabling makes no edge
        drv_val <= 1'b1;
        drv_oe  <= 1'b1;
        flip(1);
        for (i = 0; i < n; i++)
        begin
            if (bits[i])
            begin
                flip(66);
                flip(67);
            end
            else
                flip(133);
        end
        if (glitch > 0)
            flip(glitch);
        // Quiet long enough that the release edge only restarts timing
        repeat (200) @(posedge clk_sys);
        drv_oe <= 1'b0;
    endtask

    // ==========================================================
    // Decoder of what the block sends
    always @(posedge clk_sys)
    begin
        got  <= 1'b0;
        prev <= line;
        if (!listen)
        begin
            cnt  <= 0;
            half <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 1;
            if (line !== prev)
            begin
                cnt <= 0;
                // A lost or odd first edge only starts timing
                if (cnt < 20 || cnt > 180)
                    half <= 1'b0;
                else if (cnt > 99)
                begin
                    got     <= 1'b1;
                    got_bit <= 1'b0;
                end
                else if (half)
                begin
                    got     <= 1'b1;
                    got_bit <= 1'b1;
                    half    <= 1'b0;
                end
                else
                    half <= 1'b1;
            end
        end
    end
endmodule

/* File: test/tb_pd_bmc_line_phy.sv */
// Self-checking bench for the biphase-mark line coder
`timescale 1ns/100ps
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module tb_pd_bmc_line_phy;
    localparam int PRE = 4;
    logic       clk_sys, nrst, orientation, tx_start, tx_valid, tx_bit;
    logic       tx_last, tx_ready, tx_busy, tx_underrun;
    logic [3:0] tx_peak_level, tx_level;
    logic       a_in, a_out, a_oe, b_in, b_out, b_oe;
    logic       rx_bit_valid, rx_bit_value, rx_bit_error;
    logic       peer_oe, peer_val, oe_sel, out_sel, prev_oe, prev_out, e1;
    logic       peer_got, peer_bit;
    logic [1:0] e2;
    logic       exp_tx[$];
    logic [1:0] exp_rx[$];
    int         fails, n_compared, seed, cycles, hold, disp, other;
    int         exp_under, seen_under, k;

    pd_bmc_line_phy #(.PREAMBLE_BITS(PRE)) uut
    (
        .clk_sys(clk_sys), .nrst(nrst), .orientation(orientation),
        .tx_peak_level(tx_peak_level), .tx_start(tx_start),
        .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_last(tx_last),
        .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_underrun(tx_underrun),
        .tx_level(tx_level), .config_channel_pin_a_in(a_in),
        .config_channel_pin_a_out(a_out), .config_channel_pin_a_oe(a_oe),
        .config_channel_pin_b_in(b_in), .config_channel_pin_b_out(b_out),
        .config_channel_pin_b_oe(b_oe), .rx_bit_valid(rx_bit_valid),
        .rx_bit_value(rx_bit_value), .rx_bit_error(rx_bit_error)
    );

    pd_remote_port peer
    (
        .clk_sys(clk_sys), .line(orientation ? b_in : a_in),
        .listen(oe_sel), .drv_oe(peer_oe), .drv_val(peer_val),
        .got(peer_got), .got_bit(peer_bit)
    );

    // ==========================================================
    // Wire levels; the attach bias reads high when nobody drives
    assign a_in = a_oe ? a_out : (!orientation && peer_oe) ? peer_val : 1'b1;
    assign b_in = b_oe ? b_out : (orientation && peer_oe) ? peer_val : 1'b1;
    assign oe_sel  = orientation ? b_oe : a_oe;
    assign out_sel = orientation ? b_out : a_out;

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // Drivers
    task automatic send_frame(input int n, input bit under);
        logic [3:0] lvl;
        logic       b;
        int         i, t;
        lvl = $random(seed);
        for (i = 0; i < PRE; i++)
            exp_tx.push_back(i[0]);
        @(negedge clk_sys);
        `CHECK(oe_sel, 1'b0)
        tx_peak_level = lvl;
        tx_start = 1'b1;
        @(negedge clk_sys);
        tx_start = 1'b0;
        `CHECK(oe_sel, 1'b1)
        `CHECK(out_sel, 1'b0)
        `CHECK(tx_level, lvl)
        @(negedge clk_sys);
        for (i = 0; i < n; i++)
        begin
            b = $random(seed);
            tx_valid = !under;
            tx_bit = b;
            tx_last = (i == n - 1);
            // A start while busy must be ignored
            tx_start = (i == 1);
            if (!under)
                exp_tx.push_back(b);
            for (t = 0; t < 700 && tx_ready !== 1'b1; t++)
                @(negedge clk_sys);
            @(negedge clk_sys);
            if (under)
                break;
        end
        exp_under += under;
        tx_valid = 1'b0;
        tx_last = 1'b0;
        tx_start = 1'b0;
        for (t = 0; t < 400 && tx_busy !== 1'b0; t++)
            @(negedge clk_sys);
        `CHECK(tx_busy, 1'b0)
    endtask

    task automatic rx_frame(input int n, input bit glitch);
        logic [31:0] bits;
        int          i;
        bits = $random(seed);
        for (i = 0; i < n; i++)
            exp_rx.push_back({1'b0, bits[i]});
        if (glitch)
            exp_rx.push_back(2'b10);
        // Let the released wire go quiet so the first edge only times
        repeat (200) @(negedge clk_sys);
        peer.send(bits, n, glitch ? 10 : 0);
        repeat (150) @(negedge clk_sys);
    endtask

    // ==========================================================
    // Watcher
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            end_of_test();
        end
        if (!nrst)
        begin
            prev_oe = 1'b0;
            disp = 0;
            other = 0;
        end
        else
        begin
            if (peer_got)
            begin
                e1 = exp_tx.size() > 0 ? exp_tx.pop_front() : 1'bx;
                `CHECK(peer_bit, e1)
            end
            if (rx_bit_valid || rx_bit_error)
            begin
                e2 = exp_rx.size() > 0 ? exp_rx.pop_front() : 2'bxx;
                `CHECK({rx_bit_error, rx_bit_value & rx_bit_valid}, e2)
            end
            seen_under += tx_underrun;
            if (oe_sel)
            begin
                hold = (out_sel !== prev_out) ? 1 : hold + 1;
                disp += out_sel ? 1 : -1;
                other |= orientation ? a_oe : b_oe;
            end
            else if (prev_oe)
            begin
                `CHECK(hold, 66)
                `CHECK(disp <= 200 && disp >= -200, 1'b1)
                `CHECK(other, 0)
                disp = 0;
                other = 0;
            end
            prev_oe = oe_sel;
            prev_out = out_sel;
        end
    end

    initial
    begin
        seed = 32772;
        nrst = 1'b0;
        orientation = 1'b0;
        tx_peak_level = 4'h0;
        tx_start = 1'b0;
        tx_valid = 1'b0;
        tx_bit = 1'b0;
        tx_last = 1'b0;
        repeat (10) @(negedge clk_sys);
        `CHECK({a_oe, b_oe}, 2'b00)
        nrst = 1'b1;
        for (k = 0; k < 4; k++)
        begin
            orientation = k[0];
            send_frame(3 + 2 * k, 1'b0);
            rx_frame(5 + k, k[1]);
        end
        send_frame(3, 1'b1);
        // Reset in mid-frame must release the pin at once
        @(negedge clk_sys);
        tx_start = 1'b1;
        @(negedge clk_sys);
        tx_start = 1'b0;
        repeat (20) @(negedge clk_sys);
        nrst = 1'b0;
        #1 `CHECK({a_oe, b_oe}, 2'b00)
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
        send_frame(8, 1'b0);
        repeat (300) @(negedge clk_sys);
        `CHECK(seen_under, exp_under)
        `CHECK(exp_tx.size() + exp_rx.size(), 0)
        end_of_test();
    end
endmodule
